// ===== design/uhcdf_map.svh
// offsets, fields, reset values and result codes of the channel engine
`ifndef UHCDF_MAP_SVH
`define UHCDF_MAP_SVH
`define UHCDF_OFS_CTRL 8'h00
`define UHCDF_OFS_MAXPKT 8'h04
`define UHCDF_OFS_COUNT 8'h08
`define UHCDF_OFS_RESULT 8'h0C
`define UHCDF_OFS_FIFO_WR 8'h10
`define UHCDF_OFS_FIFO_RD 8'h14
`define UHCDF_OFS_FREE 8'h18
`define UHCDF_OFS_READABLE 8'h1C
`define UHCDF_OFS_INT_STAT 8'h20
`define UHCDF_OFS_INT_CLR 8'h24
`define UHCDF_OFS_INT_EN 8'h28
`define UHCDF_OFS_DMA_LEFT 8'h2C
`define UHCDF_OFS_COUNT_B0 8'h30
`define UHCDF_OFS_COUNT_B3 8'h3C
`define UHCDF_CTRL_GO 0
`define UHCDF_CTRL_DIR_IN 1
`define UHCDF_CTRL_AUTO_ZLP 2
`define UHCDF_CTRL_CPU_WR 4
`define UHCDF_CTRL_CPU_RD 5
`define UHCDF_CTRL_DMA 6
`define UHCDF_CTRL_DMA_DIR 7
`define UHCDF_CTRL_IDE 8
`define UHCDF_CTRL_IDE_DIR 9
`define UHCDF_CTRL_IDE_TRANSFER_START 10
`define UHCDF_CTRL_W 11
`define UHCDF_INT_DONE 0
`define UHCDF_INT_CHANGED 1
`define UHCDF_CTRL_RESET 11'h000
`define UHCDF_MAXPKT_RESET 11'h040
`define UHCDF_RC_OK 4'h0
`define UHCDF_RC_TOO_LONG 4'h1
`define UHCDF_RC_TOO_SHORT 4'h2
`endif

// ===== design/uhcdf_pkg.sv
// types shared by the channel data-flow engine
package uhcdf_pkg;
  typedef enum logic [3:0] {
    UHCDF_ST_IDLE = 4'b0001,
    UHCDF_ST_SEND = 4'b0010,
    UHCDF_ST_WAIT = 4'b0100,
    UHCDF_ST_RECV = 4'b1000
  } uhcdf_state_e;
endpackage

// ===== design/uhcdf_channel.sv
// host channel data-flow engine: apb registers, channel fifo, transaction sequencing
//
// Notes on behaviour
// [RL1] automatic data flow, or single transactions by re-arming go.
// [RL2] out packet length is min of remaining count and max length.
// [RL3] out transaction only with a full packet queued, sent in order.
// [RL4] remaining count drops by bytes sent per out transaction.
// [RL5] count at zero clears go and sets count-done flag.
// [RL6] cpu writes need cpu_write_attach; full fifo drops them.
// [RL7] dma fill with direction 0; stalled while fifo full.
// [RL8] ide fill with direction 0 after start; stalled while full.
// [RL9] in expects min length; starts only with max length free.
// [RL10] in count drops by bytes received; zero clears go, sets done.
// [RL11] too long: no handshake, go cleared, code set, fifo untouched.
// [RL12] too short: go cleared, code set, bytes still committed.
// [RL13] cpu reads in arrival order; empty fifo is not popped.
// [RL14] dma drain with direction 1; bytes left shown; stalled when empty.
// [RL15] ide drain with direction 1 after start; stalled when empty.
// [RL16] auto empty packet acts on out transfers only.
// [RL17] exact max-length ending keeps go, sends an empty packet next.
// [RL18] good empty packet clears go, sets count-done flag.
// [RL19] remaining counter 16 bits on control channel, else 32, byte-writable.
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/10ps
`include "uhcdf_map.svh"
module uhcdf_channel
  import uhcdf_pkg::*;
#(
  parameter int CNT_W = 32,
  parameter int DEPTH = 1024
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sie_sched,
  output logic             sie_start,
  output logic             sie_dir_in,
  output logic      [10:0] sie_len,
  output logic      [7:0]  sie_tx_data,
  output logic             sie_tx_valid,
  input  wire logic        sie_tx_ready,
  input  wire logic [7:0]  sie_rx_data,
  input  wire logic        sie_rx_valid,
  input  wire logic        sie_done,
  input  wire logic        sie_ok,
  input  wire logic [3:0]  sie_err_code,
  input  wire logic [11:0] sie_rx_len,
  input  wire logic [7:0]  dma_wdata,
  input  wire logic        dma_wvalid,
  output logic             dma_wready,
  output logic      [7:0]  dma_rdata,
  output logic             dma_rvalid,
  input  wire logic        dma_rready,
  input  wire logic [7:0]  ide_wdata,
  input  wire logic        ide_wvalid,
  output logic             ide_wready,
  output logic      [7:0]  ide_rdata,
  output logic             ide_rvalid,
  input  wire logic        ide_rready,
  output logic             irq
);

  localparam int AW = $clog2(DEPTH);

  function automatic logic [11:0] pkt_len(input logic [CNT_W-1:0] c, input logic [10:0] m);
    if (c < CNT_W'(m)) pkt_len = 12'(c); // [RL2] [RL9]
    else pkt_len = {1'b0, m};
  endfunction

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a <= `UHCDF_OFS_COUNT_B3) && (a[1:0] == 2'b00);
  endfunction

  uhcdf_state_e          st_reg;
  logic [`UHCDF_CTRL_W-1:0] ctrl_reg;
  logic [10:0]           maxpkt_reg;
  logic [CNT_W-1:0]      cnt_reg;
  logic [3:0]            result_reg;
  logic [1:0]            int_stat_reg;
  logic [1:0]            int_en_reg;
  logic [11:0]           plen_reg;
  logic [11:0]           tx_left_reg;
  logic                  zlp_pend_reg;
  logic                  zlp_sent_reg;
  logic [7:0]            mem [DEPTH];
  logic [AW-1:0]         wr_ptr_reg;
  logic [AW-1:0]         rd_ptr_reg;
  logic [AW:0]           lvl_reg;
  logic [AW:0]           spec_reg;
  logic [AW:0]           free_w;

  logic acc_setup, acc_done, wr_cmt, rd_cmt, go, dir_in;
  logic dma_fill, dma_drain, ide_fill, ide_drain, cpu_wr, cpu_rd;
  logic rx_wr, tx_load, drn_take, drn_load, dma_acc, ide_acc, fill_wr;
  logic in_done, in_discard, in_commit;
  logic [7:0] fill_data;
  logic [11:0] cur_len;
  logic [31:0] rd_mux;

  assign go        = ctrl_reg[`UHCDF_CTRL_GO];
  assign dir_in    = ctrl_reg[`UHCDF_CTRL_DIR_IN];
  assign free_w    = (AW+1)'(DEPTH) - lvl_reg - spec_reg;
  assign acc_setup = psel && penable && !pready;
  assign acc_done  = psel && penable && pready;
  assign wr_cmt    = acc_done && pwrite;
  assign rd_cmt    = acc_done && !pwrite;
  assign dma_fill  = ctrl_reg[`UHCDF_CTRL_DMA] && !ctrl_reg[`UHCDF_CTRL_DMA_DIR] && !dir_in;
  assign dma_drain = ctrl_reg[`UHCDF_CTRL_DMA] && ctrl_reg[`UHCDF_CTRL_DMA_DIR] && dir_in;
  assign ide_fill  = ctrl_reg[`UHCDF_CTRL_IDE] && ctrl_reg[`UHCDF_CTRL_IDE_TRANSFER_START]
                     && !ctrl_reg[`UHCDF_CTRL_IDE_DIR] && !dir_in;
  assign ide_drain = ctrl_reg[`UHCDF_CTRL_IDE] && ctrl_reg[`UHCDF_CTRL_IDE_TRANSFER_START]
                     && ctrl_reg[`UHCDF_CTRL_IDE_DIR] && dir_in;
  // full fifo drops the cpu byte rather than overwriting the oldest
  assign cpu_wr    = wr_cmt && (paddr == `UHCDF_OFS_FIFO_WR) && ctrl_reg[`UHCDF_CTRL_CPU_WR]
                     && !dir_in && (free_w != '0); // [RL6]
  assign cpu_rd    = rd_cmt && (paddr == `UHCDF_OFS_FIFO_RD) && ctrl_reg[`UHCDF_CTRL_CPU_RD]
                     && dir_in && (lvl_reg != '0); // [RL13]
  assign dma_acc   = dma_wready && dma_wvalid; // [RL7]
  assign ide_acc   = ide_wready && ide_wvalid; // [RL8]
  assign fill_wr   = dma_acc || ide_acc || cpu_wr;
  assign fill_data = dma_acc ? dma_wdata : (ide_acc ? ide_wdata : pwdata[7:0]);
  // bytes beyond the free space are lost, but an overrun discards them anyway
  assign rx_wr     = (st_reg == UHCDF_ST_RECV) && sie_rx_valid && (free_w != '0);
  assign tx_load   = (st_reg == UHCDF_ST_SEND) && (tx_left_reg != '0)
                     && (!sie_tx_valid || sie_tx_ready); // [RL3]
  assign drn_take  = (dma_rvalid && dma_rready) || (ide_rvalid && ide_rready);
  assign drn_load  = (dma_drain || ide_drain) && (lvl_reg != '0)
                     && ((!dma_rvalid && !ide_rvalid) || drn_take); // [RL14] [RL15]
  assign in_done   = (st_reg == UHCDF_ST_RECV) && sie_done;
  assign in_discard = in_done && (!sie_ok || (sie_rx_len > plen_reg)); // [RL11]
  assign in_commit = in_done && !in_discard; // [RL12]
  assign cur_len   = zlp_pend_reg ? 12'h000 : pkt_len(cnt_reg, maxpkt_reg);

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `UHCDF_OFS_CTRL:     rd_mux = 32'(ctrl_reg);
      `UHCDF_OFS_MAXPKT:   rd_mux = 32'(maxpkt_reg);
      `UHCDF_OFS_COUNT:    rd_mux = 32'(cnt_reg);
      `UHCDF_OFS_RESULT:   rd_mux = 32'(result_reg);
      `UHCDF_OFS_FIFO_RD:  rd_mux = 32'(mem[rd_ptr_reg]);
      `UHCDF_OFS_FREE:     rd_mux = 32'(free_w);
      `UHCDF_OFS_READABLE: rd_mux = 32'(lvl_reg);
      `UHCDF_OFS_INT_STAT: rd_mux = 32'(int_stat_reg);
      `UHCDF_OFS_INT_EN:   rd_mux = 32'(int_en_reg);
      `UHCDF_OFS_DMA_LEFT: rd_mux = 32'(lvl_reg) + 32'(dma_rvalid || ide_rvalid);
      default: begin
        if (paddr >= `UHCDF_OFS_COUNT_B0 && paddr <= `UHCDF_OFS_COUNT_B3) begin
          rd_mux = 32'((32'(cnt_reg) >> {paddr[3:2], 3'b000}) & 32'h0000_00FF);
        end
      end
    endcase
  end

  // apb slave: one wait state, so prdata is always registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc_setup;
      pslverr <= acc_setup && !addr_hit(paddr);
      if (acc_setup && !pwrite) begin
        prdata <= addr_hit(paddr) ? rd_mux : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      maxpkt_reg <= `UHCDF_MAXPKT_RESET;
      int_en_reg <= 2'b00;
    end else if (wr_cmt) begin
      if (paddr == `UHCDF_OFS_MAXPKT) maxpkt_reg <= pwdata[10:0];
      if (paddr == `UHCDF_OFS_INT_EN) int_en_reg <= pwdata[1:0];
    end
  end

  // one direction active, so fill and rx writes never collide
  always_ff @(posedge clk) begin
    if (rx_wr) begin
      mem[wr_ptr_reg + AW'(spec_reg)] <= sie_rx_data;
    end else if (fill_wr) begin
      mem[wr_ptr_reg] <= fill_data; // [RL3]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      lvl_reg    <= '0;
      spec_reg   <= '0;
    end else begin
      logic [AW:0] add;
      logic        pop;
      add = '0;
      pop = tx_load || cpu_rd || drn_load;
      if (in_commit) begin
        add = spec_reg; // [RL12]
        wr_ptr_reg <= wr_ptr_reg + AW'(spec_reg);
        spec_reg <= '0;
      end else if (in_discard) begin
        spec_reg <= '0; // [RL11]
      end else if (rx_wr) begin
        spec_reg <= spec_reg + 1'b1;
      end else if (fill_wr) begin
        add = (AW+1)'(1);
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      lvl_reg <= lvl_reg + add - (AW+1)'(pop);
    end
  end

  // fill readies keep a byte of slack since they are registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_wready <= 1'b0;
      ide_wready <= 1'b0;
    end else begin
      dma_wready <= dma_fill && (free_w > (AW+1)'(1)); // [RL7]
      ide_wready <= ide_fill && (free_w > (AW+1)'(1)); // [RL8]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_rvalid <= 1'b0;
      ide_rvalid <= 1'b0;
      dma_rdata  <= 8'h00;
      ide_rdata  <= 8'h00;
    end else if (drn_load) begin
      dma_rvalid <= dma_drain;
      ide_rvalid <= !dma_drain;
      dma_rdata  <= mem[rd_ptr_reg];
      ide_rdata  <= mem[rd_ptr_reg];
    end else if (drn_take) begin
      dma_rvalid <= 1'b0; // [RL14] [RL15]
      ide_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sie_tx_valid <= 1'b0;
      sie_tx_data  <= 8'h00;
    end else if (tx_load) begin
      sie_tx_valid <= 1'b1;
      sie_tx_data  <= mem[rd_ptr_reg];
    end else if (sie_tx_ready) begin
      sie_tx_valid <= 1'b0;
    end
  end

  // sequencer, control bits and remaining count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg       <= UHCDF_ST_IDLE;
      ctrl_reg     <= `UHCDF_CTRL_RESET;
      cnt_reg      <= '0;
      result_reg   <= `UHCDF_RC_OK;
      plen_reg     <= 12'h000;
      tx_left_reg  <= 12'h000;
      zlp_pend_reg <= 1'b0;
      zlp_sent_reg <= 1'b0;
      sie_start    <= 1'b0;
      sie_dir_in   <= 1'b0;
      sie_len      <= 11'h000;
    end else begin
      sie_start <= 1'b0;
      if (wr_cmt && paddr == `UHCDF_OFS_CTRL) begin
        ctrl_reg <= pwdata[`UHCDF_CTRL_W-1:0]; // [RL1]
        if (!pwdata[`UHCDF_CTRL_GO]) zlp_pend_reg <= 1'b0;
      end
      if (wr_cmt && paddr == `UHCDF_OFS_COUNT) cnt_reg <= pwdata[CNT_W-1:0];
      if (wr_cmt && paddr >= `UHCDF_OFS_COUNT_B0 && paddr <= `UHCDF_OFS_COUNT_B3) begin
        for (int i = 0; i < CNT_W / 8; i++) begin
          if (paddr[3:2] == 2'(i)) cnt_reg[8*i +: 8] <= pwdata[7:0]; // [RL19]
        end
      end
      unique case (st_reg)
        UHCDF_ST_IDLE: begin
          if (go && sie_sched) begin
            if (!dir_in && (lvl_reg >= (AW+1)'(cur_len))
                && (cur_len != '0 || zlp_pend_reg)) begin
              st_reg       <= UHCDF_ST_SEND; // [RL3]
              plen_reg     <= cur_len; // [RL2]
              tx_left_reg  <= cur_len;
              zlp_sent_reg <= zlp_pend_reg; // [RL17]
              zlp_pend_reg <= 1'b0;
              sie_start    <= 1'b1;
              sie_dir_in   <= 1'b0;
              sie_len      <= cur_len[10:0];
            end else if (dir_in && cnt_reg != '0 && free_w >= (AW+1)'(maxpkt_reg)) begin
              st_reg     <= UHCDF_ST_RECV; // [RL9]
              plen_reg   <= pkt_len(cnt_reg, maxpkt_reg);
              sie_start  <= 1'b1;
              sie_dir_in <= 1'b1;
              sie_len    <= 11'(pkt_len(cnt_reg, maxpkt_reg));
            end
          end
        end
        UHCDF_ST_SEND: begin
          if (tx_load) tx_left_reg <= tx_left_reg - 1'b1;
          else if (tx_left_reg == '0 && (!sie_tx_valid || sie_tx_ready)) st_reg <= UHCDF_ST_WAIT;
        end
        UHCDF_ST_WAIT: begin
          if (sie_done) begin
            st_reg <= UHCDF_ST_IDLE;
            if (!sie_ok) begin
              ctrl_reg[`UHCDF_CTRL_GO] <= 1'b0;
              result_reg <= sie_err_code;
            end else if (zlp_sent_reg) begin
              ctrl_reg[`UHCDF_CTRL_GO] <= 1'b0; // [RL18]
            end else begin
              cnt_reg <= cnt_reg - CNT_W'(plen_reg); // [RL4]
              if (cnt_reg == CNT_W'(plen_reg)) begin
                if (ctrl_reg[`UHCDF_CTRL_AUTO_ZLP] && plen_reg == {1'b0, maxpkt_reg}) begin
                  zlp_pend_reg <= 1'b1; // [RL16] [RL17]
                end else begin
                  ctrl_reg[`UHCDF_CTRL_GO] <= 1'b0; // [RL5]
                end
              end
            end
          end
        end
        UHCDF_ST_RECV: begin
          if (sie_done) begin
            st_reg <= UHCDF_ST_IDLE;
            if (!sie_ok) begin
              ctrl_reg[`UHCDF_CTRL_GO] <= 1'b0;
              result_reg <= sie_err_code;
            end else if (sie_rx_len > plen_reg) begin
              ctrl_reg[`UHCDF_CTRL_GO] <= 1'b0; // [RL11]
              result_reg <= `UHCDF_RC_TOO_LONG;
            end else begin
              cnt_reg <= cnt_reg - CNT_W'(sie_rx_len); // [RL10]
              if (sie_rx_len < plen_reg) begin
                ctrl_reg[`UHCDF_CTRL_GO] <= 1'b0; // [RL12]
                result_reg <= `UHCDF_RC_TOO_SHORT;
              end else if (cnt_reg == CNT_W'(sie_rx_len)) begin
                ctrl_reg[`UHCDF_CTRL_GO] <= 1'b0; // [RL10]
              end
            end
          end
        end
      endcase
    end
  end

  // sticky events; a set in the clearing cycle survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_reg <= 2'b00;
      irq          <= 1'b0;
    end else begin
      logic [1:0] set;
      logic [1:0] nxt;
      set = 2'b00;
      if (st_reg == UHCDF_ST_WAIT && sie_done && sie_ok
          && (zlp_sent_reg || (cnt_reg == CNT_W'(plen_reg)
          && !(ctrl_reg[`UHCDF_CTRL_AUTO_ZLP] && plen_reg == {1'b0, maxpkt_reg})))) begin
        set[`UHCDF_INT_DONE] = 1'b1; // [RL5] [RL18]
      end
      if (in_commit && sie_rx_len == plen_reg && cnt_reg == CNT_W'(sie_rx_len)) begin
        set[`UHCDF_INT_DONE] = 1'b1; // [RL10]
      end
      if (in_done && (in_discard || sie_rx_len < plen_reg)) begin
        set[`UHCDF_INT_CHANGED] = 1'b1; // [RL11] [RL12]
      end
      if (st_reg == UHCDF_ST_WAIT && sie_done && !sie_ok) set[`UHCDF_INT_CHANGED] = 1'b1;
      nxt = int_stat_reg;
      if (wr_cmt && paddr == `UHCDF_OFS_INT_CLR) nxt = nxt & ~pwdata[1:0];
      nxt = nxt | set;
      int_stat_reg <= nxt;
      irq <= |(nxt & int_en_reg);
    end
  end

endmodule // uhcdf_channel

// ===== tb/uhcdf_monitor.sv
// port assertions for the host channel engine
`timescale 1ns/10ps
module uhcdf_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sie_sched,
  input wire logic        sie_start,
  input wire logic        sie_dir_in,
  input wire logic [10:0] sie_len,
  input wire logic [7:0]  sie_tx_data,
  input wire logic        sie_tx_valid,
  input wire logic        sie_tx_ready,
  input wire logic        sie_done
);
  logic [11:0] sent_reg;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // bytes taken so far in the current outbound packet
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sent_reg <= 12'h000;
    else if (sie_start) sent_reg <= 12'h000;
    else if (sie_tx_valid && sie_tx_ready) sent_reg <= sent_reg + 12'h001;
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_out_start;
    sie_start && !sie_dir_in && sie_len != 11'h000;
  endsequence
  chk_apb_wait: assert property (s_setup ##1 s_wait |=> pready)
    else $error("apb answer late");
  chk_slverr_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("slave error outside access");
  chk_start_cause: assert property (sie_start |-> $past(sie_sched) && !$past(sie_start))
    else $error("start without schedule");
  chk_done_gap: assert property (sie_done |=> !sie_start)
    else $error("start right after done");
  chk_len_stands: assert property (!sie_start |-> $stable(sie_len) && $stable(sie_dir_in))
    else $error("length changed mid transaction");
  chk_tx_out_only: assert property (sie_tx_valid |-> !sie_dir_in)
    else $error("byte sent inbound");
  chk_tx_prompt: assert property (s_out_start |=> sie_tx_valid)
    else $error("no data after start");
  chk_tx_hold: assert property (sie_tx_valid && !sie_tx_ready
      |=> sie_tx_valid && $stable(sie_tx_data))
    else $error("stalled byte not held");
  chk_tx_bound: assert property (sie_tx_valid && sie_tx_ready |-> sent_reg < {1'h0, sie_len})
    else $error("too many bytes");
endmodule // uhcdf_monitor
bind uhcdf_channel uhcdf_monitor mon (
  .clk, .rst_n, .psel, .penable, .pready, .pslverr, .sie_sched, .sie_start, .sie_dir_in,
  .sie_len, .sie_tx_data, .sie_tx_valid, .sie_tx_ready, .sie_done
);

// ===== tb/uhcdf_sie_model.sv
// peripheral model: takes outbound packets, answers inbound requests
`timescale 1ns/10ps
module uhcdf_sie_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  rx_delta,
  output logic             sie_sched,
  input  wire logic        sie_start,
  input  wire logic        sie_dir_in,
  input  wire logic [10:0] sie_len,
  input  wire logic        sie_tx_valid,
  output logic             sie_tx_ready,
  output logic      [7:0]  sie_rx_data,
  output logic             sie_rx_valid,
  output logic             sie_done,
  output logic             sie_ok,
  output logic      [3:0]  sie_err_code,
  output logic      [11:0] sie_rx_len
);
  logic        busy_reg;
  logic        in_reg;
  logic [11:0] cnt_reg;
  logic [11:0] goal_reg;
  logic [2:0]  tick_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {busy_reg, in_reg, cnt_reg, goal_reg, tick_reg} <= '0;
      {sie_sched, sie_tx_ready, sie_rx_data, sie_rx_valid} <= '0;
      {sie_done, sie_ok, sie_err_code, sie_rx_len} <= '0;
    end else begin
      tick_reg <= tick_reg + 3'h1;
      sie_sched <= !busy_reg && tick_reg == 3'h0;
      // stalls one cycle in four so the sender must hold its byte
      sie_tx_ready <= tick_reg[1:0] != 2'h3;
      sie_done <= 1'h0;
      sie_rx_valid <= 1'h0;
      // idle data line never repeats the last byte
      sie_rx_data <= ~sie_rx_data;
      if (sie_start) begin
        busy_reg <= 1'h1;
        in_reg <= sie_dir_in;
        cnt_reg <= 12'h000;
        // inbound packets carry the asked length plus the bench's signed offset
        goal_reg <= {1'h0, sie_len} + (sie_dir_in ? {{4{rx_delta[7]}}, rx_delta} : 12'h000);
      end else if (busy_reg && cnt_reg != goal_reg) begin
        if (in_reg) begin
          sie_rx_valid <= 1'h1;
          sie_rx_data <= sie_rx_data + 8'h3B + cnt_reg[7:0];
          cnt_reg <= cnt_reg + 12'h001;
        end else if (sie_tx_valid && sie_tx_ready) begin
          cnt_reg <= cnt_reg + 12'h001;
        end
      end else if (busy_reg) begin
        // too long a packet is judged by the engine from the reported length
        busy_reg <= 1'h0;
        sie_done <= 1'h1;
        sie_ok <= 1'h1;
        sie_rx_len <= in_reg ? goal_reg : 12'h000;
      end
    end
  end
endmodule // uhcdf_sie_model

// ===== tb/tb_usb_host_channel_data_flow.sv
// bench: register bus tasks, peripheral model, transfer scenarios
`timescale 1ns/10ps
`include "uhcdf_map.svh"
module tb_usb_host_channel_data_flow;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, errq;
  logic        sie_sched, sie_start, sie_dir_in, sie_tx_valid, sie_tx_ready;
  logic        sie_rx_valid, sie_done, sie_ok, dma_wvalid, dma_wready;
  logic [7:0]  paddr, sie_tx_data, sie_rx_data, dma_wdata, rx_delta;
  logic [10:0] sie_len;
  logic [3:0]  sie_err_code;
  logic [11:0] sie_rx_len;
  logic [31:0] pwdata, prdata, rnd, rdq;
  logic [7:0]  txq[$], rxq[$], dq[$];
  logic [10:0] lenq[$], elq[$];
  int          fail_count, num_checks;
  uhcdf_channel dut (
    .clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .sie_sched, .sie_start, .sie_dir_in, .sie_len, .sie_tx_data, .sie_tx_valid,
    .sie_tx_ready, .sie_rx_data, .sie_rx_valid, .sie_done, .sie_ok, .sie_err_code,
    .sie_rx_len, .dma_wdata, .dma_wvalid, .dma_wready, .dma_rdata(), .dma_rvalid(),
    .dma_rready(1'h0), .ide_wdata(8'h00), .ide_wvalid(1'h0), .ide_wready(), .ide_rdata(),
    .ide_rvalid(), .ide_rready(1'h0), .irq
  );
  uhcdf_sie_model peer (
    .clk, .rst_n, .rx_delta, .sie_sched, .sie_start, .sie_dir_in, .sie_len, .sie_tx_valid,
    .sie_tx_ready, .sie_rx_data, .sie_rx_valid, .sie_done, .sie_ok, .sie_err_code, .sie_rx_len
  );
  always #50 clk = ~clk;
  // link capture, so checks need no design internals
  always @(posedge clk) begin
    if (sie_start) lenq.push_back(sie_len);
    if (sie_tx_valid && sie_tx_ready) txq.push_back(sie_tx_data);
    if (sie_rx_valid) rxq.push_back(sie_rx_data);
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [10:0] exp_len(input logic [31:0] r, input logic [10:0] mx);
    return (r < {21'h0, mx}) ? r[10:0] : mx;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rdq = prdata;
    errq = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(nm, e, rdq);
  endtask
  task automatic wait_idle();
    do apb(1'h0, `UHCDF_OFS_CTRL, 32'h0); while (rdq[`UHCDF_CTRL_GO] !== 1'h0);
  endtask
  task automatic post(input logic [31:0] rem, input logic [3:0] code, input logic [1:0] st);
    rchk("count", `UHCDF_OFS_COUNT, rem);
    rchk("result", `UHCDF_OFS_RESULT, {28'h0, code});
    rchk("status", `UHCDF_OFS_INT_STAT, {30'h0, st});
    apb(1'h0, `UHCDF_OFS_INT_EN, 32'h0);
    chk("irq", {31'h0, |(rdq[1:0] & st)}, {31'h0, irq});
    apb(1'h1, `UHCDF_OFS_INT_CLR, 32'h3);
    rchk("status cleared", `UHCDF_OFS_INT_STAT, 32'h0);
    chk("irq low", 32'h0, {31'h0, irq});
  endtask
  task automatic run_out(input logic [31:0] tot, input logic [10:0] mx, input logic zlp,
                         input logic dma);
    logic [31:0] rem;
    logic [31:0] ctl;
    rem = tot;
    txq.delete();
    lenq.delete();
    dq.delete();
    elq.delete();
    ctl = (32'h1 << (dma ? `UHCDF_CTRL_DMA : `UHCDF_CTRL_CPU_WR)) | {29'h0, zlp, 2'h0};
    apb(1'h1, `UHCDF_OFS_MAXPKT, {21'h0, mx});
    apb(1'h1, `UHCDF_OFS_COUNT, tot);
    apb(1'h1, `UHCDF_OFS_CTRL, ctl);
    repeat (tot) begin
      rnd = lfsr(rnd);
      dq.push_back(rnd[7:0]);
      if (!dma) apb(1'h1, `UHCDF_OFS_FIFO_WR, {24'h0, rnd[7:0]});
    end
    apb(1'h1, `UHCDF_OFS_CTRL, ctl | 32'h1);
    for (int i = 0; dma && i < dq.size(); i++) begin
      dma_wdata <= dq[i];
      dma_wvalid <= 1'h1;
      do @(posedge clk); while (dma_wready !== 1'h1);
    end
    dma_wvalid <= 1'h0;
    while (rem != 0) begin
      elq.push_back(exp_len(rem, mx));
      rem = rem - {21'h0, elq[$]};
    end
    if (zlp && tot % mx == 0) elq.push_back(11'h0);
    wait_idle();
    chk("packets", elq.size(), lenq.size());
    foreach (elq[i]) chk("length", {21'h0, elq[i]}, {21'h0, lenq[i]});
    foreach (dq[i]) chk("byte", {24'h0, dq[i]}, {24'h0, txq[i]});
    post(32'h0, `UHCDF_RC_OK, 2'h1);
  endtask
  task automatic run_in(input logic [31:0] tot, input logic [10:0] mx, input logic [7:0] dl);
    logic [31:0] rem;
    logic [31:0] got;
    logic [31:0] nin;
    logic [3:0]  code;
    rem = tot;
    nin = 32'h0;
    code = `UHCDF_RC_OK;
    rxq.delete();
    lenq.delete();
    elq.delete();
    rx_delta <= dl;
    apb(1'h1, `UHCDF_OFS_MAXPKT, {21'h0, mx});
    apb(1'h1, `UHCDF_OFS_COUNT, tot);
    // empty packet enable set too: it must add nothing inbound
    apb(1'h1, `UHCDF_OFS_CTRL, 32'h27);
    while (rem != 0 && code == `UHCDF_RC_OK) begin
      elq.push_back(exp_len(rem, mx));
      got = {21'h0, elq[$]} + {{24{dl[7]}}, dl};
      if (got > {21'h0, elq[$]}) code = `UHCDF_RC_TOO_LONG;
      else begin
        nin = nin + got;
        rem = rem - got;
        if (got < {21'h0, elq[$]}) code = `UHCDF_RC_TOO_SHORT;
      end
    end
    wait_idle();
    chk("packets", elq.size(), lenq.size());
    foreach (elq[i]) chk("length", {21'h0, elq[i]}, {21'h0, lenq[i]});
    rchk("readable", `UHCDF_OFS_READABLE, nin);
    for (int i = 0; i < nin; i++) rchk("rx byte", `UHCDF_OFS_FIFO_RD, {24'h0, rxq[i]});
    post(rem, code, code == `UHCDF_RC_OK ? 2'h1 : 2'h2);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    complete_run();
  end
  initial begin
    {clk, rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {dma_wdata, dma_wvalid, rx_delta, fail_count, num_checks} = '0;
    rnd = 32'h7BF8;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rchk("ctrl reset", `UHCDF_OFS_CTRL, 32'h0);
    rchk("maxpkt reset", `UHCDF_OFS_MAXPKT, 32'h40);
    rchk("status reset", `UHCDF_OFS_INT_STAT, 32'h0);
    apb(1'h0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, errq});
    for (int i = 0; i < 4; i++) apb(1'h1, 8'h30 + 8'(4 * i), 32'h11 * (i + 1));
    rchk("count bytes", `UHCDF_OFS_COUNT, 32'h44332211);
    apb(1'h1, `UHCDF_OFS_INT_EN, 32'h1);
    run_out(32'h6, 11'h4, 1'h0, 1'h0);
    repeat (3) begin
      rnd = lfsr(rnd);
      run_out({27'h0, rnd[4:0]} + 32'h1, {8'h0, rnd[10:8]} + 11'h1, 1'h0, 1'h0);
    end
    // masked interrupt: status sets, output stays low
    apb(1'h1, `UHCDF_OFS_INT_EN, 32'h0);
    run_out(32'h8, 11'h4, 1'h1, 1'h1);
    apb(1'h1, `UHCDF_OFS_INT_EN, 32'h3);
    run_in(32'h6, 11'h4, 8'h00);
    run_in(32'h8, 11'h4, 8'hFF);
    run_in(32'h4, 11'h4, 8'h01);
    complete_run();
  end
endmodule // tb_usb_host_channel_data_flow
